// >>> hdl/spd_pkg.sv
// Purpose: shared constants and carriers for the serial port data path
// Assumes: one 40 MHz clock, synchronous active-high reset
// Notes:   character size codes follow the usual 0..3,7 encoding
package spd_pkg;
  localparam int unsigned CLK_HZ        = 40000000;
  localparam logic [2:0]  CSZ_5         = 3'h0;
  localparam logic [2:0]  CSZ_6         = 3'h1;
  localparam logic [2:0]  CSZ_7         = 3'h2;
  localparam logic [2:0]  CSZ_8         = 3'h3;
  localparam logic [2:0]  CSZ_9         = 3'h7;
  localparam logic [3:0]  BITS_5        = 4'h5;
  localparam logic [3:0]  BITS_9        = 4'h9;
  localparam logic [3:0]  OVS           = 4'hF;
  localparam logic [3:0]  OVS_MID       = 4'h7;
  localparam int          RX_DEPTH      = 2;
  localparam logic [8:0]  DATA_RESET    = 9'h000;

  typedef struct packed {
    logic       ninth;
    logic       frame_err;
    logic       overrun_err;
    logic       parity_err;
    logic [7:0] data;
  } spd_rx_word_s;

  typedef struct packed {
    logic [2:0] char_size_sel;
    logic       parity_enable;
    logic       parity_odd;
    logic       two_stop;
    logic       sync_mode;
  } spd_format_s;

  typedef enum logic [1:0] {
    TX_IDLE, TX_START, TX_SHIFT, TX_STOP
  } spd_tx_state_e;

  typedef enum logic [1:0] {
    RX_IDLE, RX_START, RX_SHIFT, RX_STOP
  } spd_rx_state_e;
endpackage

// >>> hdl/spd_rx_fifo.sv
// Purpose: two-entry receive buffer holding a character with its flags
// Assumes: push and pop use valid/ready; flush empties at once
// Notes:   read data come out of a register
`timescale 1ns/100ps
module spd_rx_fifo (
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic                  flush,
  input  wire logic                  in_valid,
  output logic                       in_ready,
  input  wire spd_pkg::spd_rx_word_s in_word,
  output logic                       out_valid,
  input  wire logic                  out_ready,
  output spd_pkg::spd_rx_word_s      out_word
);
  spd_pkg::spd_rx_word_s mem_reg [spd_pkg::RX_DEPTH];
  logic                  wr_ptr_reg;
  logic                  rd_ptr_reg;
  logic [1:0]            count_reg;
  logic                  push;
  logic                  pop;

  assign in_ready = (count_reg != 2'h2);
  assign push     = in_valid && in_ready;
  assign pop      = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_word;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || flush) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  // output register shows the head entry
  always_ff @(posedge clk) begin
    if (srst || flush) begin
      out_valid <= 1'b0;
      out_word  <= '0;
    end else begin
      out_valid <= (count_reg + {1'b0, push} - {1'b0, pop}) != 2'h0;
      if (pop) begin
        out_word <= (count_reg == 2'h2) ? mem_reg[~rd_ptr_reg] : in_word;
      end else if (count_reg == 2'h0 && push) begin
        out_word <= in_word;
      end
    end
  end
endmodule // spd_rx_fifo

// >>> hdl/spd_data_path.sv
// Purpose: transmit and receive data path with buffer and status flags
// Assumes: baud_tick is 16x bit rate; ext clock pin already synchronous
// Notes:   register fields are plain ports; pin overrides via enables
//
// Overview of operation
// - buffer empty flag high when transmit buffer empty, else low
// - data register write clears the buffer empty flag
// - buffer empty request is level while enabled and flag set
// - transmit complete sets when frame sent and buffer empty
// - transmit complete clears on interrupt service or write of one
// - transmit complete request pulses when the flag becomes set
// - parity bit inserted after data bits before first stop bit
// - clearing transmit enable waits until shifter and buffer drain
// - disabled transmitter releases the serial output pin
// - receive enable takes over the serial input pin
// - synchronous mode receiver uses the external transfer clock
// - reception starts on valid start bit, samples bits to first stop
// - second stop bit ignored by receiver
// - on first stop bit frame moves into receive buffer
// - unused upper data bits read as zero for short characters
// - ninth bit and error flags travel with each character
// - frame is start, data lsb first, parity, stop bits; idle high
// - shifter loads buffered character when idle or after last stop
// - rx complete reflects unread data; disabling receiver flushes
// - parity is xor of data bits, inverted for odd
`timescale 1ns/100ps
module spd_data_path (
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire spd_pkg::spd_format_s  format,
  input  wire logic                  transmit_enable,
  input  wire logic                  receive_enable,
  input  wire logic                  tx_buffer_empty_irq_en,
  input  wire logic                  tx_complete_irq_en,
  input  wire logic                  ninth_tx_bit,
  input  wire logic                  baud_tick,
  input  wire logic                  data_wr,
  input  wire logic [7:0]            data_wdata,
  input  wire logic                  data_rd,
  input  wire logic                  tx_complete_wr1,
  input  wire logic                  tx_complete_ack,
  input  wire logic                  serial_in_pin,
  input  wire logic                  ext_transfer_clock_pin,
  output logic                       serial_out_pin,
  output logic                       serial_out_oe,
  output logic                       serial_in_owned,
  output logic                       tx_buffer_empty,
  output logic                       tx_complete,
  output logic                       tx_buffer_empty_irq,
  output logic                       tx_complete_irq,
  output logic                       rx_complete,
  output logic [7:0]                 rx_data,
  output logic                       ninth_rx_bit,
  output logic                       frame_error,
  output logic                       overrun_error,
  output logic                       parity_error
);
  ////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [3:0] char_bits(input logic [2:0] sel);
    unique case (sel)
      spd_pkg::CSZ_5: char_bits = spd_pkg::BITS_5;
      spd_pkg::CSZ_6: char_bits = 4'h6;
      spd_pkg::CSZ_7: char_bits = 4'h7;
      spd_pkg::CSZ_9: char_bits = spd_pkg::BITS_9;
      default:        char_bits = 4'h8;
    endcase
  endfunction

  function automatic logic [8:0] mask_bits(input logic [8:0] d,
                                           input logic [3:0] n);
    logic [8:0] m;
    m = 9'h1FF >> (4'h9 - n);
    mask_bits = d & m;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // bit timing: 16x baud ticks or external clock edges
  logic       xck_d_reg;
  logic       xck_rise;
  logic       xck_fall;
  logic [3:0] bits_n;

  assign bits_n   = char_bits(format.char_size_sel);
  assign xck_rise = ext_transfer_clock_pin && !xck_d_reg;
  assign xck_fall = !ext_transfer_clock_pin && xck_d_reg;

  always_ff @(posedge clk) begin
    xck_d_reg <= ext_transfer_clock_pin;
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit buffer and shifter
  logic                  txbuf_full_reg;
  logic [8:0]            txbuf_reg;
  spd_pkg::spd_tx_state_e tx_state_reg;
  logic [8:0]            tx_shift_reg;
  logic [3:0]            tx_cnt_reg;
  logic [3:0]            tx_ovs_reg;
  logic                  tx_par_reg;
  logic                  tx_par_phase_reg;
  logic                  tx_stop2_reg;
  logic                  tx_on_reg;
  logic                  tx_step;
  logic                  tx_load;
  logic                  tx_frame_done;
  logic                  tx_busy;

  assign tx_busy = (tx_state_reg != spd_pkg::TX_IDLE);
  assign tx_step = format.sync_mode ? xck_rise
                 : (baud_tick && tx_ovs_reg == spd_pkg::OVS);
  // load when idle, or right at the end of the last stop bit
  assign tx_load = txbuf_full_reg && tx_on_reg &&
                   (!tx_busy || tx_frame_done);

  always_ff @(posedge clk) begin
    if (srst) begin
      txbuf_full_reg <= 1'b0;
      txbuf_reg      <= spd_pkg::DATA_RESET;
    end else if (data_wr) begin
      // ninth bit sampled at the data write that launches it
      txbuf_full_reg <= 1'b1;
      txbuf_reg      <= {ninth_tx_bit, data_wdata};
    end else if (tx_load) begin
      txbuf_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_on_reg <= 1'b0;
    end else if (transmit_enable) begin
      tx_on_reg <= 1'b1;
    end else if (!tx_busy && !txbuf_full_reg) begin
      tx_on_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || !tx_busy) begin
      tx_ovs_reg <= 4'h0;
    end else if (baud_tick) begin
      tx_ovs_reg <= tx_ovs_reg + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_state_reg     <= spd_pkg::TX_IDLE;
      tx_shift_reg     <= 9'h1FF;
      tx_cnt_reg       <= 4'h0;
      tx_par_reg       <= 1'b0;
      tx_par_phase_reg <= 1'b0;
      tx_stop2_reg     <= 1'b0;
      tx_frame_done    <= 1'b0;
    end else begin
      tx_frame_done <= 1'b0;
      if (tx_load) begin
        tx_state_reg <= spd_pkg::TX_START;
        tx_shift_reg <= mask_bits(txbuf_reg, bits_n);
        tx_par_reg   <= ^mask_bits(txbuf_reg, bits_n)
                        ^ format.parity_odd;
        tx_cnt_reg   <= 4'h0;
        tx_par_phase_reg <= 1'b0;
        tx_stop2_reg <= 1'b0;
      end else if (tx_step) begin
        unique case (tx_state_reg)
          spd_pkg::TX_IDLE: begin
          end
          spd_pkg::TX_START: tx_state_reg <= spd_pkg::TX_SHIFT;
          spd_pkg::TX_SHIFT: begin
            if (tx_par_phase_reg || (tx_cnt_reg == bits_n - 4'h1 &&
                                      !format.parity_enable)) begin
              tx_state_reg <= spd_pkg::TX_STOP;
            end else if (tx_cnt_reg == bits_n - 4'h1) begin
              tx_par_phase_reg <= 1'b1;
            end else begin
              tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
              tx_cnt_reg   <= tx_cnt_reg + 4'h1;
            end
          end
          spd_pkg::TX_STOP: begin
            if (format.two_stop && !tx_stop2_reg) begin
              tx_stop2_reg <= 1'b1;
            end else begin
              tx_state_reg  <= spd_pkg::TX_IDLE;
              tx_frame_done <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // serial output: start low, data lsb first, parity, stop high
  always_ff @(posedge clk) begin
    if (srst) begin
      serial_out_pin <= 1'b1;
      serial_out_oe  <= 1'b0;
    end else begin
      serial_out_oe <= tx_on_reg || transmit_enable;
      unique case (tx_state_reg)
        spd_pkg::TX_START: serial_out_pin <= 1'b0;
        spd_pkg::TX_SHIFT: serial_out_pin <= tx_par_phase_reg ?
                                             tx_par_reg : tx_shift_reg[0];
        default:           serial_out_pin <= 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmitter flags and requests
  logic tx_done_set;
  assign tx_done_set = tx_frame_done && !txbuf_full_reg && !data_wr;

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_buffer_empty <= 1'b1;
      tx_complete     <= 1'b0;
      tx_buffer_empty_irq <= 1'b0;
      tx_complete_irq <= 1'b0;
    end else begin
      tx_buffer_empty <= !(data_wr || (txbuf_full_reg && !tx_load));
      if (tx_done_set) begin
        tx_complete <= 1'b1;
      end else if (tx_complete_wr1 || tx_complete_ack) begin
        tx_complete <= 1'b0;
      end
      tx_buffer_empty_irq <= tx_buffer_empty_irq_en &&
                             !(data_wr || (txbuf_full_reg && !tx_load));
      tx_complete_irq <= tx_complete_irq_en && tx_done_set &&
                         !tx_complete;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receiver
  spd_pkg::spd_rx_state_e rx_state_reg;
  logic [8:0]            rx_shift_reg;
  logic [3:0]            rx_cnt_reg;
  logic [3:0]            rx_ovs_reg;
  logic                  rx_par_phase_reg;
  logic                  rx_par_bad_reg;
  logic                  rx_sample;
  logic                  rx_in;
  logic                  rx_push;
  logic                  rx_overrun_reg;
  logic                  fifo_ready;
  logic                  fifo_valid;
  spd_pkg::spd_rx_word_s push_word;
  spd_pkg::spd_rx_word_s head_word;

  assign rx_in     = receive_enable ? serial_in_pin : 1'b1;
  assign rx_sample = format.sync_mode ? xck_fall
                   : (baud_tick && rx_ovs_reg == spd_pkg::OVS_MID);

  always_ff @(posedge clk) begin
    if (srst || rx_state_reg == spd_pkg::RX_IDLE) begin
      rx_ovs_reg <= 4'h0;
    end else if (baud_tick) begin
      rx_ovs_reg <= rx_ovs_reg + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || !receive_enable) begin
      rx_state_reg     <= spd_pkg::RX_IDLE;
      rx_shift_reg     <= 9'h000;
      rx_cnt_reg       <= 4'h0;
      rx_par_phase_reg <= 1'b0;
      rx_par_bad_reg   <= 1'b0;
      rx_push          <= 1'b0;
      push_word        <= '0;
    end else begin
      rx_push <= 1'b0;
      unique case (rx_state_reg)
        spd_pkg::RX_IDLE: begin
          if (!rx_in && (rx_sample || !format.sync_mode)) begin
            rx_state_reg     <= format.sync_mode ? spd_pkg::RX_SHIFT
                                                 : spd_pkg::RX_START;
            rx_shift_reg     <= 9'h000;
            rx_cnt_reg       <= 4'h0;
            rx_par_phase_reg <= 1'b0;
          end
        end
        spd_pkg::RX_START: begin
          if (rx_sample) begin
            // false start: line back high at bit middle
            rx_state_reg <= rx_in ? spd_pkg::RX_IDLE
                                  : spd_pkg::RX_SHIFT;
          end
        end
        spd_pkg::RX_SHIFT: begin
          if (rx_sample) begin
            if (rx_par_phase_reg) begin
              rx_par_bad_reg <= rx_in ^ (^rx_shift_reg)
                                ^ format.parity_odd;
              rx_state_reg   <= spd_pkg::RX_STOP;
            end else begin
              rx_shift_reg <= rx_shift_reg |
                              ({8'h00, rx_in} << rx_cnt_reg);
              rx_cnt_reg   <= rx_cnt_reg + 4'h1;
              if (rx_cnt_reg == bits_n - 4'h1) begin
                rx_par_phase_reg <= format.parity_enable;
                rx_state_reg <= format.parity_enable ? spd_pkg::RX_SHIFT
                                                     : spd_pkg::RX_STOP;
              end
            end
          end
        end
        spd_pkg::RX_STOP: begin
          // only the first stop bit is looked at
          if (rx_sample) begin
            rx_state_reg <= spd_pkg::RX_IDLE;
            rx_push      <= 1'b1;
            push_word.data        <= rx_shift_reg[7:0];
            push_word.ninth       <= rx_shift_reg[8];
            push_word.frame_err   <= !rx_in;
            push_word.parity_err  <= format.parity_enable &&
                                     rx_par_bad_reg;
            push_word.overrun_err <= rx_overrun_reg;
          end
        end
      endcase
    end
  end

  // overrun: a start bit seen while the buffer is full
  always_ff @(posedge clk) begin
    if (srst || !receive_enable) begin
      rx_overrun_reg <= 1'b0;
    end else if (rx_push && fifo_ready) begin
      rx_overrun_reg <= 1'b0;
    end else if (!fifo_ready && rx_state_reg == spd_pkg::RX_IDLE &&
                 !rx_in) begin
      rx_overrun_reg <= 1'b1;
    end
  end

  spd_rx_fifo u_rx_fifo (
    .clk       (clk),
    .srst      (srst),
    .flush     (!receive_enable),
    .in_valid  (rx_push),
    .in_ready  (fifo_ready),
    .in_word   (push_word),
    .out_valid (fifo_valid),
    .out_ready (data_rd),
    .out_word  (head_word)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      serial_in_owned <= 1'b0;
      rx_complete     <= 1'b0;
      rx_data         <= 8'h00;
      ninth_rx_bit    <= 1'b0;
      frame_error     <= 1'b0;
      overrun_error   <= 1'b0;
      parity_error    <= 1'b0;
    end else begin
      serial_in_owned <= receive_enable;
      rx_complete     <= fifo_valid && receive_enable;
      rx_data         <= head_word.data;
      ninth_rx_bit    <= head_word.ninth;
      frame_error     <= head_word.frame_err;
      overrun_error   <= head_word.overrun_err;
      parity_error    <= head_word.parity_err;
    end
  end
endmodule // spd_data_path

// >>> tb/spd_data_path_props.sv
// Purpose: port checker for the serial port data path
// Assumes: bound to spd_data_path, one clock, srst sync high
// Notes:   watches flags, pin ownership and receive head
`timescale 1ns/100ps
module spd_data_path_props (
  input wire logic                 clk,
  input wire logic                 srst,
  input wire spd_pkg::spd_format_s format,
  input wire logic                 transmit_enable,
  input wire logic                 receive_enable,
  input wire logic                 tx_buffer_empty_irq_en,
  input wire logic                 tx_complete_irq_en,
  input wire logic                 data_wr,
  input wire logic                 tx_complete_wr1,
  input wire logic                 tx_complete_ack,
  input wire logic                 serial_out_pin,
  input wire logic                 serial_out_oe,
  input wire logic                 serial_in_owned,
  input wire logic                 tx_buffer_empty,
  input wire logic                 tx_complete,
  input wire logic                 tx_buffer_empty_irq,
  input wire logic                 tx_complete_irq,
  input wire logic                 rx_complete,
  input wire logic [7:0]           rx_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////
  AST_RESET_VALS: assert property (disable iff (1'b0)
    srst |=> tx_buffer_empty && !tx_complete && !rx_complete)
    else $error("reset flag values wrong");
  AST_WR_CLEARS: assert property (data_wr |=> !tx_buffer_empty)
    else $error("write left buffer empty flag set");
  AST_EMPTY_IRQ: assert property (
    (tx_buffer_empty && tx_buffer_empty_irq_en) [*2] |-> tx_buffer_empty_irq)
    else $error("buffer empty request missing");
  AST_EMPTY_NOIRQ: assert property (
    (!tx_buffer_empty) [*2] |-> !tx_buffer_empty_irq)
    else $error("buffer empty request while full");
  AST_TXC_IRQ: assert property (
    $rose(tx_complete) && tx_complete_irq_en |-> ##[0:1] tx_complete_irq)
    else $error("complete request missing");
  AST_TXC_PULSE: assert property (tx_complete_irq |=> !tx_complete_irq)
    else $error("complete request longer than one cycle");
  AST_TXC_CLR: assert property (
    tx_complete && (tx_complete_wr1 || tx_complete_ack) |=> !tx_complete)
    else $error("complete flag not cleared");
  AST_TXC_SET: assert property (
    $rose(tx_complete) |-> tx_buffer_empty && serial_out_pin)
    else $error("complete set with data pending");
  AST_RX_OWN: assert property (
    receive_enable [*2] |-> serial_in_owned)
    else $error("input pin not taken over");
  AST_RX_FLUSH: assert property (
    $fell(receive_enable) |-> ##[1:3] !rx_complete)
    else $error("receive buffer not flushed");
  AST_TX_DEFER: assert property (
    $fell(transmit_enable) && !tx_buffer_empty |=> serial_out_oe)
    else $error("transmitter released with data pending");
  AST_TX_RELEASE: assert property (
    !transmit_enable && tx_complete |-> ##[0:2] !serial_out_oe)
    else $error("output pin still overridden");
  AST_SHORT_ZERO: assert property (
    rx_complete && format.char_size_sel == spd_pkg::CSZ_5
    |-> rx_data[7:5] == 3'h0)
    else $error("upper bits of short character not zero");
  cover property ($rose(tx_complete));
  cover property ($fell(receive_enable) && rx_complete);
  cover property (tx_buffer_empty_irq && tx_buffer_empty_irq_en);
endmodule // spd_data_path_props

bind spd_data_path spd_data_path_props i_props (
  .clk(clk), .srst(srst), .format(format),
  .transmit_enable(transmit_enable), .receive_enable(receive_enable),
  .tx_buffer_empty_irq_en(tx_buffer_empty_irq_en),
  .tx_complete_irq_en(tx_complete_irq_en), .data_wr(data_wr),
  .tx_complete_wr1(tx_complete_wr1), .tx_complete_ack(tx_complete_ack),
  .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
  .serial_in_owned(serial_in_owned), .tx_buffer_empty(tx_buffer_empty),
  .tx_complete(tx_complete), .tx_buffer_empty_irq(tx_buffer_empty_irq),
  .tx_complete_irq(tx_complete_irq), .rx_complete(rx_complete),
  .rx_data(rx_data)
);

// >>> tb/spd_partner.sv
// Purpose: remote serial station on the data and return lines
// Assumes: 16 clocks per bit, line idles high
// Notes:   captured frames queue up for the bench
`timescale 1ns/100ps
module spd_partner (
  input  wire logic clk,
  input  wire logic serial_out_pin,
  input  wire logic serial_out_oe,
  output logic      serial_in_pin
);
  int          rx_len = 10;
  logic [11:0] got[$];
  logic [11:0] cap;
  initial serial_in_pin = 1'b1;
  task automatic send_frame(input logic [11:0] bits, input int n);
    for (int i = 0; i <= n; i++) begin
      @(posedge clk) #2;
      serial_in_pin = (i == 0) ? 1'b0 : bits[i - 1];
      repeat (15) @(posedge clk);
    end
    @(posedge clk) #2;
    serial_in_pin = 1'b1;
  endtask
  // mid-bit sampling of the device output
  always begin
    @(posedge clk);
    if (serial_out_oe && !serial_out_pin) begin
      cap = 12'hFFF;
      repeat (8) @(posedge clk);
      for (int j = 0; j < rx_len; j++) begin
        repeat (16) @(posedge clk);
        cap[j] = serial_out_pin;
      end
      got.push_back(cap);
    end
  end
endmodule // spd_partner

// >>> tb/spd_data_path_bench.sv
// Purpose: self-checking bench for the serial port data path
// Assumes: baud tick every clock, so one bit lasts 16 clocks
// Notes:   random data and formats from seed 42
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module spd_data_path_bench;
  logic                 clk, srst, transmit_enable, receive_enable;
  logic                 empty_irq_en, txc_irq_en, ninth_tx_bit, data_wr;
  logic                 data_rd, txc_wr1, txc_ack, serial_in, xck = 1'b0;
  logic                 sout, soe, sin_owned, tbe, txc, tbe_irq, txc_irq;
  logic                 rxc, ninth_rx, ferr, oerr, perr;
  logic [7:0]           wdata, rx_data;
  spd_pkg::spd_format_s fmt;
  int                   mismatches, checked, seed, k, n;
  logic [8:0]           d, d2;
  logic [11:0]          f, g;
  logic [2:0]           sizes [5];

  spd_data_path i_dut (
    .clk(clk), .srst(srst), .format(fmt),
    .transmit_enable(transmit_enable), .receive_enable(receive_enable),
    .tx_buffer_empty_irq_en(empty_irq_en), .tx_complete_irq_en(txc_irq_en),
    .ninth_tx_bit(ninth_tx_bit), .baud_tick(1'b1), .data_wr(data_wr),
    .data_wdata(wdata), .data_rd(data_rd), .tx_complete_wr1(txc_wr1),
    .tx_complete_ack(txc_ack), .serial_in_pin(serial_in),
    .ext_transfer_clock_pin(xck), .serial_out_pin(sout),
    .serial_out_oe(soe), .serial_in_owned(sin_owned),
    .tx_buffer_empty(tbe), .tx_complete(txc), .tx_buffer_empty_irq(tbe_irq),
    .tx_complete_irq(txc_irq), .rx_complete(rxc), .rx_data(rx_data),
    .ninth_rx_bit(ninth_rx), .frame_error(ferr), .overrun_error(oerr),
    .parity_error(perr)
  );
  spd_partner i_p (
    .clk(clk), .serial_out_pin(sout), .serial_out_oe(soe),
    .serial_in_pin(serial_in)
  );
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial #14.5 forever #200 xck = ~xck;
  function automatic int nb(logic [2:0] s);
    return (s == spd_pkg::CSZ_9) ? 9 : int'(s) + 5;
  endfunction
  function automatic logic [11:0] frame_of(logic [8:0] v, int nd,
      logic pe, logic odd, logic s1, logic badp);
    logic [11:0] r;
    logic        p;
    r = 12'hFFF;
    p = odd ^ badp;
    for (int i = 0; i < nd; i++) begin
      r[i] = v[i];
      p = p ^ v[i];
    end
    if (pe) r[nd] = p;
    r[nd + int'(pe)] = s1;
    return r;
  endfunction
  function automatic logic flag(int w);
    return (w == 0) ? tbe : (w == 1) ? txc : rxc;
  endfunction
  task automatic tick(int c = 1);
    repeat (c) @(posedge clk);
    #2;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
  endtask
  task automatic wr(logic [8:0] v);
    ninth_tx_bit = v[8];
    tick();
    wdata = v[7:0];
    pulse(data_wr);
  endtask
  task automatic wait_hi(int w);
    int c;
    c = 0;
    while (c < 600 && !flag(w)) begin
      tick();
      c++;
    end
    `CHK(flag(w), 1'b1)
  endtask
  task automatic take(logic [11:0] e);
    g = (i_p.got.size() > 0) ? i_p.got.pop_front() : 12'h000;
    `CHK(g, e)
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    final_report();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 42;
    sizes = '{spd_pkg::CSZ_5, spd_pkg::CSZ_6, spd_pkg::CSZ_7,
              spd_pkg::CSZ_8, spd_pkg::CSZ_9};
    {transmit_enable, receive_enable, empty_irq_en, txc_irq_en} = 4'h0;
    {ninth_tx_bit, data_wr, data_rd, txc_wr1, txc_ack} = 5'h00;
    wdata = 8'h00;
    fmt = '0;
    srst = 1'b1;
    tick(16);
    srst = 1'b0;
    `CHK({tbe, txc, rxc, sout}, 4'h9)
    {transmit_enable, receive_enable, empty_irq_en, txc_irq_en} = 4'hF;
    tick(2);
    `CHK(tbe_irq, 1'b1)
    for (k = 0; k < 10; k++) begin
      fmt.char_size_sel = sizes[k % 5];
      fmt.parity_enable = 1'($random(seed));
      fmt.parity_odd = 1'($random(seed));
      n = nb(fmt.char_size_sel);
      i_p.rx_len = n + int'(fmt.parity_enable) + 1;
      d = (k < 5) ? 9'h1FF >> k : 9'($random(seed));
      wr(d);
      wait_hi(1);
      `CHK(tbe, 1'b1)
      take(frame_of(d, n, fmt.parity_enable, fmt.parity_odd, 1'b1, 1'b0));
      if (k % 2) pulse(txc_wr1);
      else pulse(txc_ack);
      `CHK(txc, 1'b0)
    end
    $display("tx frames done");
    fmt = '0;
    fmt.char_size_sel = spd_pkg::CSZ_8;
    i_p.rx_len = 9;
    d = 9'($random(seed));
    d2 = 9'($random(seed));
    wr(d);
    wait_hi(0);
    wr(d2);
    `CHK(tbe, 1'b0)
    transmit_enable = 1'b0;
    wait_hi(1);
    `CHK(i_p.got.size(), 2)
    take(frame_of(d, 8, 1'b0, 1'b0, 1'b1, 1'b0));
    take(frame_of(d2, 8, 1'b0, 1'b0, 1'b1, 1'b0));
    tick(3);
    `CHK(soe, 1'b0)
    pulse(txc_wr1);
    $display("tx disable done");
    fmt.two_stop = 1'b1;
    for (k = 0; k < 10; k++) begin
      fmt.char_size_sel = sizes[k % 5];
      fmt.parity_enable = (k == 3) ? 1'b1 : 1'($random(seed));
      fmt.parity_odd = 1'($random(seed));
      n = nb(fmt.char_size_sel);
      d = 9'($random(seed));
      f = frame_of(d, n, fmt.parity_enable, fmt.parity_odd, k != 9, k == 3);
      i_p.send_frame(f, n + int'(fmt.parity_enable) + 2);
      wait_hi(2);
      `CHK(rx_data, d[7:0] & (8'hFF >> (8 - ((n > 8) ? 8 : n))))
      if (n == 9) `CHK(ninth_rx, d[8])
      `CHK(perr, k == 3)
      `CHK(ferr, k == 9)
      pulse(data_rd);
      tick(3);
      if (k < 9) `CHK(rxc, 1'b0)
    end
    receive_enable = 1'b0;
    tick(3);
    `CHK(rxc, 1'b0)
    receive_enable = 1'b1;
    tick(2);
    fmt = '0;
    fmt.char_size_sel = spd_pkg::CSZ_8;
    d = 9'($random(seed));
    d2 = 9'($random(seed));
    i_p.send_frame(frame_of(d, 8, 1'b0, 1'b0, 1'b1, 1'b0), 9);
    i_p.send_frame(frame_of(d2, 8, 1'b0, 1'b0, 1'b1, 1'b0), 9);
    i_p.send_frame(frame_of(d, 8, 1'b0, 1'b0, 1'b1, 1'b0), 9);
    wait_hi(2);
    `CHK({oerr, rx_data}, {1'b0, d[7:0]})
    pulse(data_rd);
    tick(3);
    `CHK(rxc, 1'b1)
    `CHK(rx_data, d2[7:0])
    pulse(data_rd);
    i_p.send_frame(frame_of(d2, 8, 1'b0, 1'b0, 1'b1, 1'b0), 9);
    `CHK({rxc, oerr, rx_data}, {2'b11, d2[7:0]})
    receive_enable = 1'b0;
    tick(3);
    `CHK(rxc, 1'b0)
    fmt.sync_mode = 1'b1;
    receive_enable = 1'b1;
    i_p.send_frame(frame_of(d, 8, 1'b0, 1'b0, 1'b1, 1'b0), 9);
    wait_hi(2);
    `CHK({ferr, rx_data}, {1'b0, d[7:0]})
    $display("rx frames done");
    final_report();
  end
endmodule // spd_data_path_bench
